/* File: pifrc_pkg.sv */
package pifrc_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam int          FLAG_W = 8;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  OFS_EVENT_FLAGS  = 8'h0c;
  localparam logic [7:0]  OFS_POWER_CTRL   = 8'h10;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h14;
  localparam logic [7:0]  OFS_IRQ_CLEAR    = 8'h18;
  localparam logic [7:0]  OFS_IRQ_ENABLE   = 8'h1c;

  // ---------------------------------------------------------------------------
  // Field positions of the event flag layout
  // ---------------------------------------------------------------------------
  localparam int          BIT_CONV_DONE    = 6;
  localparam int          BIT_SERIAL_DONE  = 3;
  localparam int          BIT_CAPT_COMP    = 2;
  localparam int          BIT_PERIOD_MATCH = 1;
  localparam int          BIT_WIDE_OVF     = 0;
  localparam logic [7:0]  FLAG_MASK        = 8'h4f;

  // ---------------------------------------------------------------------------
  // Field positions of the power control register
  // ---------------------------------------------------------------------------
  localparam int          BIT_POWER_ON     = 1;
  localparam int          BIT_BROWNOUT     = 0;

  // ---------------------------------------------------------------------------
  // Reset values and wide timer limits
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  RST_EVENT_FLAGS  = 8'h00;
  localparam logic [7:0]  RST_IRQ_ENABLE   = 8'h00;
  localparam logic        RST_POWER_ON     = 1'b0;
  localparam logic        RST_BROWNOUT     = 1'b0;
  localparam logic [15:0] WIDE_TIMER_MAX   = 16'hffff;
  localparam logic [15:0] WIDE_TIMER_ZERO  = 16'h0000;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCP_OFF     = 2'b00,
    CCP_CAPTURE = 2'b01,
    CCP_COMPARE = 2'b10,
    CCP_PWM     = 2'b11
  } pifrc_ccp_mode_e;

  typedef enum logic [1:0] {
    RS_SETTLE1 = 2'b00,
    RS_SETTLE2 = 2'b01,
    RS_SAMPLE  = 2'b10,
    RS_DONE    = 2'b11
  } pifrc_rst_state_e;

  typedef struct packed {
    logic            conversion_done;
    logic            serial_xfer_done;
    logic            capture_event;
    pifrc_ccp_mode_e ccp_mode;
    logic [15:0]     compare_value;
    logic [15:0]     wide_timer;
    logic [7:0]      narrow_timer;
    logic [7:0]      narrow_timer_period;
  } pifrc_periph_s;

endpackage

/* File: pifrc_sticky_bit.sv */
`timescale 1ns/1ns
module pifrc_sticky_bit (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic wr,
  input  wire logic wdata,
  output logic      q
);

  logic q_d;

  // A hardware set in the same cycle as a software write always wins.
  assign q_d = set | (wr ? wdata : q); // [R14]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0; // [R15]
    end else begin
      q <= q_d;
    end
  end

endmodule

/* File: pifrc_top.sv */
`timescale 1ns/1ns
// Functional notes
// R1: Conversion done sets flag bit 6.
// R2: Bits 7, 5 and 4 read zero.
// R3: Serial transfer done sets flag bit 3.
// R4: Capture mode capture sets flag bit 2.
// R5: Compare mode match sets bit 2; PWM none.
// R6: Narrow timer equals period sets bit 1.
// R7: Wide timer rollover sets flag bit 0.
// R8: Power control flags tell reset causes apart.
// R9: Brown-out flag undefined after power-on.
// R10: Software sets brown-out flag after power-on.
// R11: Brown-out clear, power-on set means brown-out.
// R12: Software ignores brown-out flag if detection off.
// R13: Flags set regardless of any enable.
// R14: Hardware set beats simultaneous software clear.
// R15: Flags reset zero, software read/writable.
module pifrc_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   por_rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [pifrc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [pifrc_pkg::DATA_W-1:0] pwdata,
  output logic      [pifrc_pkg::DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire pifrc_pkg::pifrc_periph_s periph,
  input  wire logic                   brownout_detect_enable,
  input  wire logic                   brownout_reset_cause,
  output logic                        irq
);

  import pifrc_pkg::*;

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0]  prdata_q;
  logic [DATA_W-1:0]  prdata_d;
  logic               pslverr_q;
  logic               pslverr_d;
  logic [FLAG_W-1:0]  flags;
  logic [FLAG_W-1:0]  status;
  logic [FLAG_W-1:0]  enable_q;
  logic [FLAG_W-1:0]  enable_d;
  logic [FLAG_W-1:0]  evt;
  logic               power_on_q;
  logic               power_on_d;
  logic               brownout_q;
  logic               brownout_d;
  logic [1:0]         brownout_detect_enable_sync_q;
  logic [1:0]         bocause_sync_q;
  logic [1:0]         por_sync_q;
  logic               por_release_n;
  pifrc_rst_state_e   rst_state_q;
  pifrc_rst_state_e   rst_state_d;
  logic               period_eq_q;
  logic               compare_eq_q;
  logic [15:0]        wide_prev_q;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire setup_phase  = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_flags    = (paddr == OFS_EVENT_FLAGS);
  wire hit_power    = (paddr == OFS_POWER_CTRL);
  wire hit_status   = (paddr == OFS_IRQ_STATUS);
  wire hit_clear    = (paddr == OFS_IRQ_CLEAR);
  wire hit_enable   = (paddr == OFS_IRQ_ENABLE);
  wire hit_any      = hit_flags | hit_power | hit_status | hit_clear | hit_enable;
  wire wr_access    = access_phase & pwrite;
  wire wr_flags     = wr_access & hit_flags;
  wire wr_power     = wr_access & hit_power;
  wire wr_clear     = wr_access & hit_clear;
  wire wr_enable    = wr_access & hit_enable;

  // ---------------------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------------------
  // The slave never inserts wait states, so every access ends in two cycles.
  assign pready  = access_phase;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q & access_phase;

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  wire [FLAG_W-1:0] power_view = (FLAG_W'(power_on_q) << BIT_POWER_ON)
                               | (FLAG_W'(brownout_q) << BIT_BROWNOUT); // [R8]
  wire [FLAG_W-1:0] read_mux   = hit_flags  ? flags :
                                 hit_power  ? power_view :
                                 hit_status ? status :
                                 hit_enable ? enable_q : '0;

  // Read data is captured in the setup cycle and held through the access.
  assign prdata_d  = setup_phase ? {{(DATA_W-FLAG_W){1'b0}}, read_mux} : prdata_q;
  assign pslverr_d = setup_phase ? ~hit_any : pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // The error is decoded with the read data, so it stands for the whole access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------------------
  // Timer conditions are edge detected so a value held across many prescaled
  // ticks raises only one event; a stuck timer cannot refire the flag.
  wire period_eq  = (periph.narrow_timer == periph.narrow_timer_period);
  wire compare_eq = (periph.wide_timer == periph.compare_value);
  wire in_capture = (periph.ccp_mode == CCP_CAPTURE);
  wire in_compare = (periph.ccp_mode == CCP_COMPARE);

  wire ev_conv    = periph.conversion_done; // [R1]
  wire ev_serial  = periph.serial_xfer_done; // [R3]
  wire ev_capture = in_capture & periph.capture_event; // [R4]
  wire ev_compare = in_compare & compare_eq & ~compare_eq_q; // [R5]
  wire ev_period  = period_eq & ~period_eq_q; // [R6]
  wire ev_ovf     = (wide_prev_q == WIDE_TIMER_MAX)
                  & (periph.wide_timer == WIDE_TIMER_ZERO); // [R7]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_eq_q <= 1'b0;
    end else begin
      period_eq_q <= period_eq;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_eq_q <= 1'b0;
    end else begin
      compare_eq_q <= compare_eq;
    end
  end

  // The previous timer value is kept whole, so a reload straight to zero from
  // any value other than all ones never counts as a rollover.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_prev_q <= WIDE_TIMER_ZERO;
    end else begin
      wide_prev_q <= periph.wide_timer;
    end
  end

  // Events feed the flags directly; no enable gates them.
  always_comb begin
    evt                   = '0;
    evt[BIT_CONV_DONE]    = ev_conv;
    evt[BIT_SERIAL_DONE]  = ev_serial;
    evt[BIT_CAPT_COMP]    = ev_capture | ev_compare;
    evt[BIT_PERIOD_MATCH] = ev_period;
    evt[BIT_WIDE_OVF]     = ev_ovf; // [R13]
  end

  // ---------------------------------------------------------------------------
  // Event flags and interrupt status
  // ---------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++) begin : g_bit
      if (FLAG_MASK[i]) begin : g_impl
        pifrc_sticky_bit u_flag (
          .pclk    (pclk),
          .presetn (presetn),
          .set     (evt[i]),
          .wr      (wr_flags),
          .wdata   (pwdata[i]),
          .q       (flags[i])
        ); // [R15]
        // The status copy is cleared only through the clear register, so the
        // interrupt handler and polling software never race on one bit.
        pifrc_sticky_bit u_status (
          .pclk    (pclk),
          .presetn (presetn),
          .set     (evt[i]),
          .wr      (wr_clear & pwdata[i]),
          .wdata   (1'b0),
          .q       (status[i])
        ); // [R14]
      end else begin : g_unimpl
        assign flags[i]  = 1'b0; // [R2]
        assign status[i] = 1'b0; // [R2]
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Interrupt enable and output
  // ---------------------------------------------------------------------------
  // Only implemented bits can be enabled, so a stray write cannot arm a bit
  // that never sets.
  assign enable_d = wr_enable ? (pwdata[FLAG_W-1:0] & FLAG_MASK) : enable_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= RST_IRQ_ENABLE;
    end else begin
      enable_q <= enable_d;
    end
  end

  // The interrupt is a level that drops only when its status or enable clears.
  assign irq = |(status & enable_q);

  // ---------------------------------------------------------------------------
  // Reset cause pins
  // ---------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brownout_detect_enable_sync_q <= 2'b00;
    end else begin
      brownout_detect_enable_sync_q <= {brownout_detect_enable_sync_q[0], brownout_detect_enable};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bocause_sync_q <= 2'b00;
    end else begin
      bocause_sync_q <= {bocause_sync_q[0], brownout_reset_cause};
    end
  end

  // ---------------------------------------------------------------------------
  // Reset cause sequencer
  // ---------------------------------------------------------------------------
  // The cause is sampled only once the synchronisers have settled after the
  // release of reset; later changes on the pins are ignored until next reset.
  always_comb begin
    rst_state_d = rst_state_q;
    unique case (rst_state_q)
      RS_SETTLE1: rst_state_d = RS_SETTLE2;
      RS_SETTLE2: rst_state_d = RS_SAMPLE;
      RS_SAMPLE:  rst_state_d = RS_DONE;
      RS_DONE:    rst_state_d = RS_DONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state_q <= RS_SETTLE1;
    end else begin
      rst_state_q <= rst_state_d;
    end
  end

  wire bo_detected = (rst_state_q == RS_SAMPLE) & brownout_detect_enable_sync_q[1] & bocause_sync_q[1];

  // ---------------------------------------------------------------------------
  // Power control flags
  // ---------------------------------------------------------------------------
  // These are cleared only by power-on reset, by a software write or, for the brown-out flag, by a detected
  // brown-out, so software can read what the last reset was. The brown-out flag has no
  // meaningful value after power-on; it comes up at a fixed level only so the
  // logic stays defined, and software must set it itself.
  assign power_on_d = wr_power ? pwdata[BIT_POWER_ON] : power_on_q; // [R10]
  assign brownout_d = bo_detected ? 1'b0 :
                      wr_power    ? pwdata[BIT_BROWNOUT] : brownout_q; // [R11]

  // The power-on reset pin takes effect at once but is released through two
  // flip-flops, so the flags never leave reset close to a clock edge.
  always_ff @(posedge pclk or negedge por_rst_n) begin
    if (!por_rst_n) begin
      por_sync_q <= 2'b00;
    end else begin
      por_sync_q <= {por_sync_q[0], 1'b1};
    end
  end

  assign por_release_n = por_sync_q[1];

  always_ff @(posedge pclk or negedge por_release_n) begin
    if (!por_release_n) begin
      power_on_q <= RST_POWER_ON;
    end else begin
      power_on_q <= power_on_d; // [R8]
    end
  end

  always_ff @(posedge pclk or negedge por_release_n) begin
    if (!por_release_n) begin
      brownout_q <= RST_BROWNOUT; // [R9]
    end else begin
      brownout_q <= brownout_d; // [R11]
    end
  end

endmodule

/* File: pifrc_chk.sv */
`timescale 1ns/1ns
// --------------------
// Port checks
// --------------------
module pifrc_chk (
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pwrite,
  input wire logic [pifrc_pkg::ADDR_W-1:0]  paddr,
  input wire logic [pifrc_pkg::DATA_W-1:0]  prdata,
  input wire logic                          pready,
  input wire logic                          pslverr,
  input wire pifrc_pkg::pifrc_periph_s      periph
);
  import pifrc_pkg::*;
  wire mapped = paddr == OFS_EVENT_FLAGS || paddr == OFS_POWER_CTRL || paddr == OFS_IRQ_STATUS ||
                paddr == OFS_IRQ_CLEAR || paddr == OFS_IRQ_ENABLE;
  wire rd_flags = psel && !penable && !pwrite && paddr == OFS_EVENT_FLAGS;
  wire per_eq = periph.narrow_timer == periph.narrow_timer_period;
  wire cmp_eq = periph.wide_timer == periph.compare_value;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY: assert property (pready == (psel && penable))
    else $error("pready wrong");
  AST_SLVERR: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr wrong");
  AST_RSVD_ZERO: assert property (rd_flags |=> (prdata & 32'hffff_ffb0) == 32'h0)
    else $error("reserved bits set");
  AST_CONV: assert property (rd_flags && $past(periph.conversion_done) |=> prdata[BIT_CONV_DONE])
    else $error("conversion flag missing");
  AST_SERIAL: assert property (rd_flags && $past(periph.serial_xfer_done) |=> prdata[BIT_SERIAL_DONE])
    else $error("serial flag missing");
  AST_CAPTURE: assert property (rd_flags && $past(periph.capture_event && periph.ccp_mode == CCP_CAPTURE)
    |=> prdata[BIT_CAPT_COMP]) else $error("capture flag missing");
  AST_COMPARE: assert property (rd_flags && $past(periph.ccp_mode == CCP_COMPARE && cmp_eq)
    && !$past(cmp_eq, 2) |=> prdata[BIT_CAPT_COMP]) else $error("compare flag missing");
  AST_PERIOD: assert property (rd_flags && $past(per_eq) && !$past(per_eq, 2) |=> prdata[BIT_PERIOD_MATCH])
    else $error("period flag missing");
  AST_WIDE_OVF: assert property (rd_flags && $past(periph.wide_timer) == WIDE_TIMER_ZERO
    && $past(periph.wide_timer, 2) == WIDE_TIMER_MAX |=> prdata[BIT_WIDE_OVF]) else $error("overflow flag missing");
endmodule

/* File: pifrc_top_test.sv */
`timescale 1ns/1ns
// --------------------
// Self-checking bench
// --------------------
module pifrc_top_test;
  import pifrc_pkg::*;
  logic              pclk, presetn, por_rst_n, psel, penable, pwrite, pready, pslverr, irq, bo_en, bo_cause, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd, d;
  logic [7:0]        en, ex;
  logic [7:0]        regs [6] = '{OFS_EVENT_FLAGS, OFS_POWER_CTRL, OFS_IRQ_STATUS, OFS_IRQ_CLEAR, OFS_IRQ_ENABLE, 8'h20};
  pifrc_periph_s     p;
  int                bad_count, checks, seed, k, m;

  pifrc_top dut (.pclk(pclk), .presetn(presetn), .por_rst_n(por_rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periph(p), .brownout_detect_enable(bo_en), .brownout_reset_cause(bo_cause), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Event pulses drop at the setup edge, so a read can follow an event at once.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic ev = 1'b0);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    p.conversion_done <= 1'b0;
    p.serial_xfer_done <= 1'b0;
    p.capture_event <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    p.conversion_done <= ev;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    p.conversion_done <= 1'b0;
  endtask

  task automatic fire(input int kind, input int mode);
    @(posedge pclk);
    p.ccp_mode <= pifrc_ccp_mode_e'(mode[1:0]);
    p.wide_timer <= (kind == 0) ? WIDE_TIMER_MAX : 16'h0100;
    p.narrow_timer <= ~p.narrow_timer_period;
    @(posedge pclk);
    case (kind)
      0: p.wide_timer <= WIDE_TIMER_ZERO;
      1: p.narrow_timer <= p.narrow_timer_period;
      2: p.wide_timer <= p.compare_value;
      3: p.serial_xfer_done <= 1'b1;
      4: p.capture_event <= 1'b1;
      default: p.conversion_done <= 1'b1;
    endcase
  endtask

  function automatic logic [7:0] expect_flag(input int kind, input int mode);
    case (kind)
      0: return 8'h1 << BIT_WIDE_OVF;
      1: return 8'h1 << BIT_PERIOD_MATCH;
      2: return (mode == CCP_COMPARE) ? 8'h1 << BIT_CAPT_COMP : 8'h0;
      3: return 8'h1 << BIT_SERIAL_DONE;
      4: return (mode == CCP_CAPTURE) ? 8'h1 << BIT_CAPT_COMP : 8'h0;
      default: return 8'h1 << BIT_CONV_DONE;
    endcase
  endfunction

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial begin
    seed = 42079;
    {presetn, por_rst_n, psel, penable, pwrite, bo_en, bo_cause} = 7'h0;
    paddr = '0;
    pwdata = '0;
    p = '0;
    p.compare_value = 16'h0200;
    p.narrow_timer = 8'h01;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    por_rst_n <= 1'b1;
    for (k = 0; k < 6; k++) begin
      apb(1'b0, regs[k], 32'h0);
      cmp(rd, 32'h0);
      cmp({31'h0, err}, {31'h0, k == 5});
    end
    for (k = 0; k < 8; k++) begin
      d = (k == 0) ? 32'hffff_ffff : $random(seed);
      apb(1'b1, k[0] ? OFS_IRQ_ENABLE : OFS_EVENT_FLAGS, d);
      apb(1'b0, k[0] ? OFS_IRQ_ENABLE : OFS_EVENT_FLAGS, 32'h0);
      cmp(rd, {24'h0, d[7:0] & FLAG_MASK});
    end
    apb(1'b1, OFS_EVENT_FLAGS, 32'h0);
    apb(1'b1, OFS_IRQ_STATUS, 32'hff);
    apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
    apb(1'b0, OFS_IRQ_STATUS, 32'h0);
    cmp(rd, 32'h0);
    d = $random(seed);
    p.narrow_timer_period <= d[7:0];
    p.narrow_timer <= ~d[7:0];
    for (k = 0; k < 6; k++) begin
      for (m = 0; m < 4; m++) begin
        en = $random(seed) & FLAG_MASK;
        ex = expect_flag(k, m);
        apb(1'b1, OFS_IRQ_ENABLE, {24'h0, en});
        fire(k, m);
        apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
        cmp(rd, {24'h0, ex});
        apb(1'b0, OFS_IRQ_STATUS, 32'h0);
        cmp(rd, {24'h0, ex});
        cmp({31'h0, irq}, {31'h0, |(ex & en)});
        apb(1'b1, OFS_EVENT_FLAGS, 32'h0);
        apb(1'b1, OFS_IRQ_CLEAR, 32'hff);
        @(negedge pclk);
        cmp({31'h0, irq}, 32'h0);
      end
    end
    apb(1'b1, OFS_EVENT_FLAGS, 32'h0, 1'b1);
    apb(1'b0, OFS_EVENT_FLAGS, 32'h0);
    cmp(rd, 32'h40);
    apb(1'b1, OFS_POWER_CTRL, 32'h3);
    apb(1'b0, OFS_POWER_CTRL, 32'h0);
    cmp(rd, 32'h3);
    for (k = 0; k < 3; k++) begin
      bo_en <= (k == 2);
      bo_cause <= (k != 0);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, OFS_POWER_CTRL, 32'h0);
      cmp(rd, (k == 2) ? 32'h2 : 32'h3);
    end
    end_of_test();
  end
endmodule

bind pifrc_top pifrc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph(periph));
